// >>> hdl/pcg_top.v
// Purpose: Peripheral clock gating, clock rate select and test clock-out
//          multiplexing for port A pins 3..0, with an Avalon-MM slave.
// Assumes: One clock ref_clk at 50 MHz; 2X and 3X clocks, the oscillator
//          clock and the stop/PLL status arrive from outside this domain.
// Notes:   Clock-out path is a sampled view, for test only; glitches and
//          aliasing are expected and accepted.
//
// What this block does
// - Select bit 9 puts oscillator clock on pad 3, else pulse output 3.
// - Select bit 8 puts system clock on pad 2, else pulse output 2.
// - Select bit 7 puts 2X system clock on pad 1, else output 1.
// - Select bit 6 puts 3X system clock on pad 0, else output 0.
// - Pad select bits 9..6 reset to zero, pads default to pulse outputs.
// - Factory test bit 5 resets to one; software writes it as one.
// - Rate bit 14 runs quad counter at system rate or 3X.
// - Rate bit 13 runs pulse generator at system rate or 3X.
// - Rate bit 12 runs two-wire run clock at system rate or 3X.
// - The 3X clock exists only while the PLL drives the system clock.
// - Enable bits 15,14,13,12,10 gate comparators, analog outputs, ADC.
// - Enable bits 6,4,2,0 gate two-wire, serial, SPI and pulse clocks.
// - A peripheral with its enable clear is stopped; its accesses do nothing.
// - In Stop mode enabled clocks stop unless retention bit is set.
// - Retention keeps a clock running in Stop only if enabled too.
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/100ps
`include "pcg_map.vh"

module pcg_top
(
  input  wire                    ref_clk,
  input  wire                    rst_n,
  // Avalon-MM slave
  input  wire [`PCG_ADDR_W-1:0]  avs_address,
  input  wire                    avs_read,
  input  wire                    avs_write,
  input  wire [`PCG_DATA_W-1:0]  avs_writedata,
  input  wire [3:0]              avs_byteenable,
  output reg  [`PCG_DATA_W-1:0]  avs_readdata,
  output reg                     avs_waitrequest,
  // Clock sources and system state, all from other domains
  input  wire                    osc_clk,
  input  wire                    sys_clk_x2,
  input  wire                    sys_clk_x3,
  input  wire                    pll_selected,
  input  wire                    stop_mode,
  // Pulse generator outputs to be multiplexed onto port A
  input  wire [3:0]              pulse_out,
  // Port A peripheral output function, pads 3..0
  output reg  [3:0]              port_a_pins,
  // Rate selects: 1 = run at 3X system clock
  output reg                     quad_counter_rate_sel,
  output reg                     pulse_gen_rate_sel,
  output reg                     two_wire_rate_sel,
  // Effective clock enables, bit positions as in the enable register
  output reg  [`PCG_REG_W-1:0]   periph_clk_en
);

  // ============================================================
  // Registers
  reg  [`PCG_REG_W-1:0] clock_output_select;
  reg  [`PCG_REG_W-1:0] peripheral_clock_rate;
  reg  [`PCG_REG_W-1:0] peripheral_clock_enable_low;
  reg  [`PCG_REG_W-1:0] stop_retention_regs;

  reg  [2:0]            sync_osc;
  reg  [2:0]            sync_x2;
  reg  [2:0]            sync_x3;
  reg  [2:0]            sync_pll;
  reg  [2:0]            sync_stop;
  reg                   osc_lvl;
  reg                   x2_lvl;
  reg                   x3_lvl;
  reg                   pll_lvl;
  reg                   stop_lvl;
  reg                   sys_div;

  wire [3:0]            word_idx;
  wire                  bus_req;
  wire                  bus_take;
  wire                  wr_take;
  reg  [`PCG_REG_W-1:0] next_rd;
  reg  [`PCG_REG_W-1:0] wr_lanes;

  assign word_idx = avs_address[`PCG_ADDR_W-1:2];
  assign bus_req  = avs_read | avs_write;
  assign bus_take = bus_req & ~avs_waitrequest;
  assign wr_take  = avs_write & ~avs_waitrequest;

  // ============================================================
  // Input synchronisers: a change counts once stages 2 and 3 agree
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_osc  <= 3'h0;
      sync_x2   <= 3'h0;
      sync_x3   <= 3'h0;
      sync_pll  <= 3'h0;
      sync_stop <= 3'h0;
    end
    else
    begin
      sync_osc  <= {sync_osc[1:0], osc_clk};
      sync_x2   <= {sync_x2[1:0], sys_clk_x2};
      sync_x3   <= {sync_x3[1:0], sys_clk_x3};
      sync_pll  <= {sync_pll[1:0], pll_selected};
      sync_stop <= {sync_stop[1:0], stop_mode};
    end
  end

  // Filtered levels; they hold until the last two stages agree
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_lvl  <= 1'b0;
      x2_lvl   <= 1'b0;
      x3_lvl   <= 1'b0;
      pll_lvl  <= 1'b0;
      stop_lvl <= 1'b0;
    end
    else
    begin
      if (sync_osc[2] == sync_osc[1])
        osc_lvl <= sync_osc[2];
      if (sync_x2[2] == sync_x2[1])
        x2_lvl <= sync_x2[2];
      if (sync_x3[2] == sync_x3[1])
        x3_lvl <= sync_x3[2];
      if (sync_pll[2] == sync_pll[1])
        pll_lvl <= sync_pll[2];
      if (sync_stop[2] == sync_stop[1])
        stop_lvl <= sync_stop[2];
    end
  end

  // System clock image: a flop cannot echo its own clock, so toggle at half
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sys_div <= 1'b0;
    else
      sys_div <= ~sys_div;
  end

  // ============================================================
  // Bus handshake: one wait cycle, then a single-cycle answer
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else if (bus_req & avs_waitrequest)
      avs_waitrequest <= 1'b0;
    else
      avs_waitrequest <= 1'b1;
  end

  // Read mux; reserved bits and unmapped words read zero
  always @*
  begin
    case (word_idx)
      `PCG_IDX_CLKOUT: next_rd = clock_output_select & `PCG_CO_MASK;
      `PCG_IDX_RATE:   next_rd = peripheral_clock_rate & `PCG_RT_MASK;
      `PCG_IDX_ENABLE: next_rd = peripheral_clock_enable_low & `PCG_EN_MASK;
      `PCG_IDX_RETAIN: next_rd = stop_retention_regs & `PCG_EN_MASK;
      default:         next_rd = 16'h0000;
    endcase
  end

  // Read data is loaded with the drop of waitrequest and held after
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata <= 32'h00000000;
    else if (avs_read & avs_waitrequest)
      avs_readdata <= {16'h0000, next_rd};
  end

  // Byte lanes 0 and 1 carry the 16-bit register; lanes 2 and 3 ignored
  always @*
  begin
    wr_lanes = 16'h0000;
    if (avs_byteenable[0])
      wr_lanes[7:0] = 8'hFF;
    if (avs_byteenable[1])
      wr_lanes[15:8] = 8'hFF;
  end

  // ============================================================
  // Register writes; reserved bits are masked off and never stored
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clock_output_select         <= `PCG_CO_RESET;
      peripheral_clock_rate       <= `PCG_RT_RESET;
      peripheral_clock_enable_low <= `PCG_EN_RESET;
      stop_retention_regs         <= `PCG_EN_RESET;
    end
    else if (wr_take)
    begin
      case (word_idx)
        `PCG_IDX_CLKOUT:
          clock_output_select <= ((avs_writedata[15:0] & wr_lanes) |
            (clock_output_select & ~wr_lanes)) & `PCG_CO_MASK;
        `PCG_IDX_RATE:
          peripheral_clock_rate <= ((avs_writedata[15:0] & wr_lanes) |
            (peripheral_clock_rate & ~wr_lanes)) & `PCG_RT_MASK;
        `PCG_IDX_ENABLE:
          peripheral_clock_enable_low <= ((avs_writedata[15:0] & wr_lanes) |
            (peripheral_clock_enable_low & ~wr_lanes)) & `PCG_EN_MASK;
        `PCG_IDX_RETAIN:
          stop_retention_regs <= ((avs_writedata[15:0] & wr_lanes) |
            (stop_retention_regs & ~wr_lanes)) & `PCG_EN_MASK;
        default:
          clock_output_select <= clock_output_select;
      endcase
    end
  end

  // ============================================================
  // Port A clock-out multiplexer, for test observation only
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      port_a_pins <= 4'h0;
    else
    begin
      port_a_pins[3] <= clock_output_select[`PCG_CO_PAD3] ?
                        osc_lvl : pulse_out[3];
      port_a_pins[2] <= clock_output_select[`PCG_CO_PAD2] ?
                        sys_div : pulse_out[2];
      port_a_pins[1] <= clock_output_select[`PCG_CO_PAD1] ?
                        x2_lvl : pulse_out[1];
      // 3X image is held low while the PLL is not the system clock
      port_a_pins[0] <= clock_output_select[`PCG_CO_PAD0] ?
                        (x3_lvl & pll_lvl) : pulse_out[0];
    end
  end

  // ============================================================
  // Rate selects fall back to system rate when no 3X clock exists
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      quad_counter_rate_sel <= 1'b0;
      pulse_gen_rate_sel    <= 1'b0;
      two_wire_rate_sel     <= 1'b0;
    end
    else
    begin
      quad_counter_rate_sel <= peripheral_clock_rate[`PCG_RT_QUAD] &
                               pll_lvl;
      pulse_gen_rate_sel    <= peripheral_clock_rate[`PCG_RT_PULSE] &
                               pll_lvl;
      two_wire_rate_sel     <= peripheral_clock_rate[`PCG_RT_TWO_WIRE] &
                               pll_lvl;
    end
  end

  // ============================================================
  // Clock gating: enable bit, then Stop mode unless retention is set.
  // A low enable also tells the peripheral to ignore its bus accesses.
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      periph_clk_en <= 16'h0000;
    else
      periph_clk_en <= peripheral_clock_enable_low & `PCG_EN_MASK &
                       ({16{~stop_lvl}} | stop_retention_regs);
  end

endmodule // pcg_top

// >>> pkg/pcg_map.vh
// Purpose: Register map, field positions and reset values of the
//          peripheral clock gate and clock-out select block.
// Assumes: Word-indexed registers; byte address is four times the index.
// Notes:   Definitions only.
`ifndef PCG_MAP_VH
`define PCG_MAP_VH

// ============================================================
// Register indices and bus geometry
`define PCG_IDX_CLKOUT      4'hA
`define PCG_IDX_RATE        4'hB
`define PCG_IDX_ENABLE      4'hC
`define PCG_IDX_RETAIN      4'hE
`define PCG_ADDR_W          6
`define PCG_DATA_W          32
`define PCG_REG_W           16

// ============================================================
// Clock output select fields
`define PCG_CO_PAD3         9
`define PCG_CO_PAD2         8
`define PCG_CO_PAD1         7
`define PCG_CO_PAD0         6
`define PCG_CO_FTEST        5
`define PCG_CO_RESET        16'h0020
`define PCG_CO_MASK         16'h03E0

// ============================================================
// Clock rate fields
`define PCG_RT_QUAD         14
`define PCG_RT_PULSE        13
`define PCG_RT_TWO_WIRE     12
`define PCG_RT_RESET        16'h0000
`define PCG_RT_MASK         16'h7000

// ============================================================
// Clock enable and stop retention fields (same bit layout)
`define PCG_EN_CMP_B        15
`define PCG_EN_CMP_A        14
`define PCG_EN_AOUT1        13
`define PCG_EN_AOUT0        12
`define PCG_EN_ADC          10
`define PCG_EN_TWO_WIRE     6
`define PCG_EN_SER_COMM     4
`define PCG_EN_SER_PERIPH   2
`define PCG_EN_PULSE        0
`define PCG_EN_RESET        16'h0000
`define PCG_EN_MASK         16'hF455

`endif

// >>> dv/pcg_top_assertions.sv
// Purpose: Port checks on the clock gate block.
// Assumes: One wait cycle per bus access.
// Notes:   Bound to pcg_top below.
`timescale 1ns/100ps
module pcg_chk
(
  input wire        ref_clk,
  input wire        rst_n,
  input wire [5:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        pll_selected,
  input wire        stop_mode,
  input wire [3:0]  port_a_pins,
  input wire        quad_counter_rate_sel,
  input wire        pulse_gen_rate_sel,
  input wire        two_wire_rate_sel,
  input wire [15:0] periph_clk_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire        req = avs_read | avs_write;
  wire        acc = avs_write & ~avs_waitrequest & (avs_byteenable == 4'hF);
  wire [2:0]  sels = {quad_counter_rate_sel, pulse_gen_rate_sel,
                      two_wire_rate_sel};
  // ==========================================================
  // Checks
  sequence s_run; !stop_mode[*8]; endsequence
  sequence s_pll; pll_selected[*8]; endsequence
  rst_out_a: assert property ($rose(rst_n) |-> periph_clk_en == 16'h0000
    && sels == 3'b000 && port_a_pins == 4'h0) else $error("reset outputs");
  en_mask_a: assert property ((periph_clk_en & 16'h0BAA) == 16'h0000)
    else $error("enable on unused bit");
  // Register lands at the write edge, output flop one edge later
  en_write_a:
    assert property (s_run ##0 (acc && avs_address == 6'h30) |-> ##2
      periph_clk_en == ($past(avs_writedata[15:0], 2) & 16'hF455))
    else $error("enable out");
  rate_nopll_a: assert property (!pll_selected[*8] |-> sels == 3'b000)
    else $error("rate without pll");
  rate_write_a:
    assert property (s_pll ##0 (acc && avs_address == 6'h2C) |-> ##2
      sels == $past(avs_writedata[14:12], 2))
    else $error("rate out");
  wait_ans_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer");
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  rd_upper_a: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read data");
endmodule // pcg_chk
bind pcg_top pcg_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pll_selected(pll_selected), .stop_mode(stop_mode),
  .port_a_pins(port_a_pins), .quad_counter_rate_sel(quad_counter_rate_sel),
  .pulse_gen_rate_sel(pulse_gen_rate_sel),
  .two_wire_rate_sel(two_wire_rate_sel), .periph_clk_en(periph_clk_en));

// >>> dv/pcg_src.sv
// Purpose: Clock sources and pulse outputs around the block.
// Assumes: Odd periods so ref_clk sampling sees them move.
// Notes:   Pulse outputs follow pat in the ref_clk domain.
`timescale 1ns/100ps
module pcg_src
(
  input  wire       ref_clk,
  input  wire       pll_on,
  input  wire [3:0] pat,
  output reg        osc_clk,
  output reg        x2_clk,
  output wire       x3_clk,
  output reg  [3:0] pulse_out
);
  reg x3_raw;
  // Free running sources
  initial
  begin
    osc_clk = 1'b0;
    x2_clk = 1'b0;
    x3_raw = 1'b0;
    pulse_out = 4'h0;
  end
  always #65.5 osc_clk = ~osc_clk;
  always #5.3 x2_clk = ~x2_clk;
  always #3.7 x3_raw = ~x3_raw;
  // No 3X clock unless the PLL runs the system
  assign x3_clk = x3_raw & pll_on;
  always @(posedge ref_clk)
    pulse_out <= pat;
endmodule // pcg_src

// >>> dv/test_periph_clock_gate_and_clkout_mux.sv
// Purpose: Directed test of the clock gate block.
// Assumes: Avalon master waits for waitrequest low.
// Notes:   Each scenario is a task.
`timescale 1ns/100ps
module test_periph_clock_gate_and_clkout_mux;
  reg         ref_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [5:0]  avs_address = 6'h00;
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h0;
  reg  [3:0]  avs_byteenable = 4'hF;
  reg         pll_selected = 1'b0;
  reg         stop_mode = 1'b0;
  reg  [3:0]  pat = 4'hA;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest;
  wire        osc_clk, x2_clk, x3_clk, quad, pulse, two;
  wire [3:0]  pulse_out, port_a_pins;
  wire [15:0] periph_clk_en;
  integer     errors = 0;
  integer     n_checks = 0;
  integer     k, n;
  reg  [15:0] rd;
  reg         p;
  always #10 ref_clk = ~ref_clk;
  pcg_src u_src (.ref_clk(ref_clk), .pll_on(pll_selected), .pat(pat),
    .osc_clk(osc_clk), .x2_clk(x2_clk), .x3_clk(x3_clk),
    .pulse_out(pulse_out));
  pcg_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .osc_clk(osc_clk),
    .sys_clk_x2(x2_clk), .sys_clk_x3(x3_clk), .pll_selected(pll_selected),
    .stop_mode(stop_mode), .pulse_out(pulse_out), .port_a_pins(port_a_pins),
    .quad_counter_rate_sel(quad), .pulse_gen_rate_sel(pulse),
    .two_wire_rate_sel(two), .periph_clk_en(periph_clk_en));
  // ==========================================================
  // Shared tasks
  task end_sim;
  begin
    if (errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  task chk(input [63:0] nm, input [15:0] s, input [15:0] e);
  begin
    n_checks = n_checks + 1;
    if (s !== e)
    begin
      errors = errors + 1;
      $display("[ERR] %0s expected %h seen %h", nm, e, s);
    end
  end
  endtask
  // One access; held until waitrequest is sampled low at a rising edge
  task bus(input w, input [5:0] a, input [15:0] d, input [3:0] be);
    integer i;
  begin
    @(posedge ref_clk);
    avs_write <= w;
    avs_read <= ~w;
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    i = 0;
    do
    begin
      @(posedge ref_clk);
      i = i + 1;
    end while (avs_waitrequest !== 1'b0 && i < 50);
    // Same edge: write lands, read data taken, then release
    rd = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      chk("wait", 16'h0, 16'h1);
      end_sim;
    end
  end
  endtask
  // ==========================================================
  // Scenarios
  task t_reset;
  begin
    bus(0, 6'h28, 0, 4'hF);
    chk("clko", rd, 16'h0020);
    bus(0, 6'h2C, 0, 4'hF);
    chk("rate", rd, 16'h0000);
    bus(0, 6'h30, 0, 4'hF);
    chk("en", rd, 16'h0000);
    chk("ena", periph_clk_en, 16'h0000);
    chk("sel", {13'h0, quad, pulse, two}, 16'h0000);
    chk("pads", {12'h0, port_a_pins}, {12'h0, pat});
  end
  endtask
  // Reserved bits dropped, byte lanes, unmapped place
  task t_enable;
  begin
    bus(1, 6'h30, 16'hFFFF, 4'hF);
    bus(0, 6'h30, 0, 4'hF);
    chk("en", rd, 16'hF455);
    chk("ena", periph_clk_en, 16'hF455);
    bus(1, 6'h30, 16'h0000, 4'h2);
    bus(1, 6'h30, 16'h0000, 4'h4);
    chk("ena", periph_clk_en, 16'h0055);
    bus(1, 6'h3C, 16'hFFFF, 4'hF);
    bus(0, 6'h3C, 0, 4'hF);
    chk("gap", rd, 16'h0000);
  end
  endtask
  task t_stop;
  begin
    bus(1, 6'h30, 16'hF455, 4'hF);
    bus(1, 6'h38, 16'h0411, 4'hF);
    stop_mode <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("stop", periph_clk_en, 16'h0411);
    bus(1, 6'h30, 16'h0011, 4'hF);
    repeat (2) @(posedge ref_clk);
    chk("stop", periph_clk_en, 16'h0011);
    stop_mode <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk("run", periph_clk_en, 16'h0011);
  end
  endtask
  task t_rate;
  begin
    // Peripherals off before their rates change
    bus(1, 6'h30, 16'h0000, 4'hF);
    pll_selected <= 1'b1;
    // PLL status needs its synchroniser delay before rates follow
    repeat (8) @(posedge ref_clk);
    for (k = 0; k < 3; k = k + 1)
    begin
      bus(1, 6'h2C, 16'h1000 << k, 4'hF);
      repeat (2) @(posedge ref_clk);
      chk("sel", {13'h0, quad, pulse, two}, 16'h0001 << k);
    end
    pll_selected <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk("nopll", {13'h0, quad, pulse, two}, 16'h0000);
  end
  endtask
  // Each pad in turn shows a moving clock, others keep pulses
  task t_pads;
  begin
    pll_selected <= 1'b1;
    for (k = 0; k < 4; k = k + 1)
    begin
      bus(1, 6'h28, 16'h0020 | (16'h0040 << k), 4'hF);
      repeat (8) @(posedge ref_clk);
      n = 0;
      p = port_a_pins[k];
      repeat (64)
      begin
        @(posedge ref_clk);
        #1;
        n = n + (port_a_pins[k] !== p);
        p = port_a_pins[k];
      end
      chk("tog", {15'h0, n > 0}, 16'h0001);
      chk("pads", {12'h0, port_a_pins & ~(4'h1 << k)},
          {12'h0, pat & ~(4'h1 << k)});
    end
    // Pad 0 selected as 3X clock, then PLL dropped: pad must stay low
    bus(1, 6'h28, 16'h0060, 4'hF);
    pll_selected <= 1'b0;
    repeat (8) @(posedge ref_clk);
    n = 0;
    repeat (32)
    begin
      @(posedge ref_clk);
      #1;
      n = n + (port_a_pins[0] !== 1'b0);
    end
    chk("pad0", n[15:0], 16'h0000);
  end
  endtask
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset;
    t_enable;
    t_stop;
    t_rate;
    t_pads;
    // Second reset in mid-run: clock-out, rate and enable registers and the outputs read back at reset values
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset;
    end_sim;
  end
endmodule // test_periph_clock_gate_and_clkout_mux
